// [hdl/tcr_top.sv]
// Timer count readback and output pin logic for two 16-bit timers, APB slave.
// Assumes the counting core supplies reload, count load and next count on pclk; enable comes from the control register.
// Contract
// RL1: Reading counts never disturbs counting
// RL2: Enabled high read latches low byte
// RL3: Next low read returns the holding byte
// RL4: Disabled low read returns live byte
// RL5: Output toggles on every reload
// RL6: Output reaches pin only via alternate function
// RL7: Count is high byte over low
// RL8: Byte writes load the counter directly
`timescale 1ns/10ps
`default_nettype none
module tcr_top
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer core
  input wire logic [1:0] reload,
  input wire logic [1:0] count_load,
  input wire logic [15:0] count_next0,
  input wire logic [15:0] count_next1,
  output logic [15:0] count0,
  output logic [15:0] count1,
  // Port pin
  input wire logic [1:0] alt_func_sel,
  input wire logic [1:0] port_data,
  output logic [1:0] pin_out
);
  logic [1:0] enable;
  logic [11:0] idx;
  logic access;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_status;
  logic mapped;
  logic [7:0] high0;
  logic [7:0] low0;
  logic [7:0] high1;
  logic [7:0] low1;
  logic [1:0] tout;
  logic [31:0] next_prdata;
  tcr_pkg::tcr_access_t acc0;
  tcr_pkg::tcr_access_t acc1;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  assign idx = paddr[13:2];
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign hit_ctrl = hit(idx, tcr_pkg::IDX_CTRL);
  assign hit_status = hit(idx, tcr_pkg::IDX_STATUS);
  assign mapped = hit(idx, tcr_pkg::IDX_T0_HIGH) || hit(idx, tcr_pkg::IDX_T0_LOW)
               || hit(idx, tcr_pkg::IDX_T1_HIGH) || hit(idx, tcr_pkg::IDX_T1_LOW)
               || hit_ctrl || hit_status;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  assign acc0 = '{wr_high: wr && hit(idx, tcr_pkg::IDX_T0_HIGH),
                  wr_low: wr && hit(idx, tcr_pkg::IDX_T0_LOW),
                  rd_high: rd && hit(idx, tcr_pkg::IDX_T0_HIGH),
                  rd_low: rd && hit(idx, tcr_pkg::IDX_T0_LOW),
                  wdata: pwdata[7:0]};
  assign acc1 = '{wr_high: wr && hit(idx, tcr_pkg::IDX_T1_HIGH),
                  wr_low: wr && hit(idx, tcr_pkg::IDX_T1_LOW),
                  rd_high: rd && hit(idx, tcr_pkg::IDX_T1_HIGH),
                  rd_low: rd && hit(idx, tcr_pkg::IDX_T1_LOW),
                  wdata: pwdata[7:0]};

  // Enable bits steer the latch and the low byte path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable <= tcr_pkg::RST_CTRL;
    else if (wr && hit_ctrl)
      enable <= pwdata[1:0];
  end

  tcr_channel u_ch0
  (
    .pclk(pclk),
    .presetn(presetn),
    .enable(enable[0]),
    .reload(reload[0]),
    .count_load(count_load[0]),
    .count_next(count_next0),
    .acc(acc0),
    .count_high_byte(high0),
    .count_low_byte(low0),
    .count(count0),
    .timer_out(tout[0])
  );

  tcr_channel u_ch1
  (
    .pclk(pclk),
    .presetn(presetn),
    .enable(enable[1]),
    .reload(reload[1]),
    .count_load(count_load[1]),
    .count_next(count_next1),
    .acc(acc1),
    .count_high_byte(high1),
    .count_low_byte(low1),
    .count(count1),
    .timer_out(tout[1])
  );

  // Plain port data unless the alternate function is selected
  assign pin_out = (alt_func_sel & tout) | (~alt_func_sel & port_data); // see RL6

  assign next_prdata =
      hit(idx, tcr_pkg::IDX_T0_HIGH) ? {24'h000000, high0}
    : hit(idx, tcr_pkg::IDX_T0_LOW) ? {24'h000000, low0}
    : hit(idx, tcr_pkg::IDX_T1_HIGH) ? {24'h000000, high1}
    : hit(idx, tcr_pkg::IDX_T1_LOW) ? {24'h000000, low1}
    : hit_ctrl ? {30'h0000000, enable}
    : hit_status ? {30'h0000000, tout}
    : 32'h00000000;

  // Data registered from the setup cycle; holding update lands at access end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end
endmodule
`default_nettype wire

// [hdl/tcr_pkg.sv]
// Package for the timer count readback block: offsets, reset values, carriers.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package tcr_pkg;
  // Printed offsets are not multiples of four: they are word indices
  localparam logic [11:0] IDX_T0_HIGH = 12'hF00;
  localparam logic [11:0] IDX_T0_LOW = 12'hF01;
  localparam logic [11:0] IDX_T1_HIGH = 12'hF08;
  localparam logic [11:0] IDX_T1_LOW = 12'hF09;
  localparam logic [11:0] IDX_CTRL = 12'hF10;
  localparam logic [11:0] IDX_STATUS = 12'hF11;
  localparam int ADDR_W = 14;
  localparam logic [7:0] RST_HIGH = 8'h00;
  localparam logic [7:0] RST_LOW = 8'h01;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam int NUM_TIMERS = 2;

  typedef struct packed {
    logic wr_high;
    logic wr_low;
    logic rd_high;
    logic rd_low;
    logic [7:0] wdata;
  } tcr_access_t;
endpackage

// [hdl/tcr_channel.sv]
// One timer's count bytes, holding register and output toggle.
// Assumes all inputs are synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module tcr_channel
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer core side and control enable
  input wire logic enable,
  input wire logic reload,
  input wire logic count_load,
  input wire logic [15:0] count_next,
  // Software access
  input wire tcr_pkg::tcr_access_t acc,
  // Results
  output logic [7:0] count_high_byte,
  output logic [7:0] count_low_byte,
  output logic [15:0] count,
  output logic timer_out
);
  logic [7:0] hold;
  logic [15:0] next_count;

  // A write wins over the counting core so software values are exact
  assign next_count = acc.wr_high ? {acc.wdata, count[7:0]}   // see RL8
                    : acc.wr_low ? {count[15:8], acc.wdata}   // see RL8
                    : count_load ? count_next : count;

  // Reads feed nothing back into the count  // see RL1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= {tcr_pkg::RST_HIGH, tcr_pkg::RST_LOW};
    else
      count <= next_count;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold <= tcr_pkg::RST_LOW;
    else if (enable && acc.rd_high)
      hold <= count[7:0]; // see RL2
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_out <= 1'b0;
    else if (reload)
      timer_out <= ~timer_out; // see RL5
  end

  assign count_high_byte = count[15:8]; // see RL7
  // Disabled timers bypass the holding register
  assign count_low_byte = enable ? hold : count[7:0]; // see RL3 see RL4
endmodule
`default_nettype wire

// [bench/tcr_checker.sv]
// Checker of readback, write and pin relations of tcr_top.
// Assumes byte address is word index times four.
`timescale 1ns/10ps
`default_nettype none
module tcr_checker
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Timer core
  input wire logic [1:0] reload,
  input wire logic [1:0] count_load,
  input wire logic [15:0] count0,
  // Port pin
  input wire logic [1:0] alt_func_sel,
  input wire logic [1:0] port_data,
  input wire logic [1:0] pin_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire rd = psel && !penable && !pwrite;
  property p_k; !wr && !count_load[0] |=> $stable(count0); endproperty
  a_k: assert property (p_k) else $error("k");
  property p_t0; reload[0] && alt_func_sel[0] ##1 alt_func_sel[0]
    |-> pin_out[0] != $past(pin_out[0]); endproperty
  a_t0: assert property (p_t0) else $error("t0");
  property p_t1; reload[1] && alt_func_sel[1] ##1 alt_func_sel[1]
    |-> pin_out[1] != $past(pin_out[1]); endproperty
  a_t1: assert property (p_t1) else $error("t1");
  property p_g0; !alt_func_sel[0] |-> pin_out[0] == port_data[0]; endproperty
  a_g0: assert property (p_g0) else $error("g0");
  property p_g1; !alt_func_sel[1] |-> pin_out[1] == port_data[1]; endproperty
  a_g1: assert property (p_g1) else $error("g1");
  property p_h; wr && paddr == 14'h3C00
    |=> count0[15:8] == $past(pwdata[7:0]); endproperty
  a_h: assert property (p_h) else $error("h");
  property p_l; wr && paddr == 14'h3C04
    |=> count0[7:0] == $past(pwdata[7:0]); endproperty
  a_l: assert property (p_l) else $error("l");
  property p_r; rd && paddr == 14'h3C00
    |=> prdata[7:0] == $past(count0[15:8]); endproperty
  a_r: assert property (p_r) else $error("r");
  c_w: cover property (wr);
  c_r: cover property (rd && paddr == 14'h3C04);
  c_t: cover property (reload[0] && alt_func_sel[0]);
endmodule
bind tcr_top tcr_checker chk_u (.*);
`default_nettype wire

// [bench/timer_count_readback_bench.sv]
// Bench for tcr_top: count readback, byte writes and pin output.
// Assumes a zero-wait APB slave at word index times four.
`timescale 1ns/10ps
`default_nettype none
module timer_count_readback_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] reload, count_load, alt_func_sel, port_data, pin_out;
  logic [15:0] count_next0, count_next1, count0, count1;
  int n_mismatch = 0;
  int tests_run = 0;
  tcr_top dut_u (.*);
  task automatic chk(string n, logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(logic [11:0] i, logic w, logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(string n, logic [11:0] i, logic [7:0] e);
    xfer(i, 1'b0, 8'h00);
    chk(n, {8'h00, e}, {8'h00, rdat[7:0]});
  endtask
  // Load stands in for the counting core moving the count
  task automatic ld(logic t, logic [15:0] v);
    count_next0 <= v;
    count_next1 <= v;
    count_load <= {t, !t};
    @(posedge pclk);
    count_load <= 2'b00;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, reload, count_load} = '0;
    {alt_func_sel, port_data, count_next0, count_next1} = '0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("h0", 12'hF00, 8'h00);
    rd("l1", 12'hF09, 8'h01);
    xfer(12'hF00, 1'b1, 8'hA5);
    xfer(12'hF01, 1'b1, 8'h3C);
    chk("c0", 16'hA53C, count0);
    rd("h0w", 12'hF00, 8'hA5);
    $display("write test done");
    xfer(12'hF10, 1'b1, 8'h01);
    ld(1'b0, 16'h1234);
    rd("h0e", 12'hF00, 8'h12);
    ld(1'b0, 16'h5678);
    rd("l0e", 12'hF01, 8'h34);
    chk("c0e", 16'h5678, count0);
    xfer(12'hF10, 1'b1, 8'h00);
    rd("l0d", 12'hF01, 8'h78);
    xfer(12'hF08, 1'b1, 8'h9A);
    xfer(12'hF09, 1'b1, 8'hBC);
    chk("c1", 16'h9ABC, count1);
    xfer(12'hF10, 1'b1, 8'h02);
    rd("ctl", 12'hF10, 8'h02);
    chk("noerr", 16'h0000, {15'h0000, rerr});
    ld(1'b1, 16'hDEF0);
    rd("h1e", 12'hF08, 8'hDE);
    ld(1'b1, 16'h1357);
    rd("l1e", 12'hF09, 8'hF0);
    chk("c1e", 16'h1357, count1);
    rd("l0x", 12'hF01, 8'h78);
    rd("bad", 12'h123, 8'h00);
    chk("err", 16'h0001, {15'h0000, rerr});
    $display("readback test done");
    alt_func_sel <= 2'b11;
    port_data <= 2'b10;
    reload <= 2'b11;
    @(posedge pclk);
    reload <= 2'b00;
    @(posedge pclk);
    chk("pin", 16'h0003, {14'h0000, pin_out});
    alt_func_sel <= 2'b00;
    @(posedge pclk);
    chk("gpio", 16'h0002, {14'h0000, pin_out});
    rd("st", 12'hF11, 8'h03);
    $display("pin test done");
    end_of_test;
  end
endmodule
`default_nettype wire
